/* shared/prs_regs.svh */
// register offsets, field positions, reset values and limits of the realign slice
//
// What this block and its host must do
// RL1: shift data on clock rise, commit on latch high
// RL2: host keeps serial clock at most 20 MHz
// RL3: host sends 24-bit word, then raises latch
// RL4: host raises latch only after last byte
// RL5: host uses clock phase zero
// RL6: sync pulse every count times spacing periods
// RL7: realign count is bits 15..12, 1 to 15
// RL8: count zero disables realignment, no pulses
// RL9: select bit 23 stores bits 13..3 as spacing
// RL10: host sets spacing multiple of denominator
// RL11: second sync after frequency load realigns phase
// RL12: host makes sync interval exceed lock time
// RL13: monitor pin selects among signals, lock detect included
// RL14: denominator 2 to 4095, 50 with dither; the 11-bit serial field here loads at most 2047
// RL15: interpolator and timer step once per reference period
// RL16: frequency load resets interpolator to fixed state
// RL17: timer restarts when count or spacing rewritten
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH
// serial word
`define PRS_WORD_BITS     24
`define PRS_SEL_LSB       0
`define PRS_SEL_MSB       1
`define PRS_LOAD_SEL_BIT  23
`define PRS_DENOM_LSB     3
`define PRS_DENOM_MSB     13
`define PRS_FRAC_LSB      2
`define PRS_FRAC_MSB      13
`define PRS_INT_LSB       14
`define PRS_INT_MSB       22
`define PRS_RCOUNT_LSB    12
`define PRS_RCOUNT_MSB    15
`define PRS_DITHER_BIT    2
// limits and reset values
`define PRS_DENOM_MIN     12'h002
`define PRS_DENOM_MIN_DITH 12'h032
`define PRS_DENOM_RST     12'h002
`define PRS_SPACING_RST   11'h001
`define PRS_RCOUNT_RST    4'h0
// ahb byte offsets
`define PRS_OFS_CTRL      8'h00
`define PRS_OFS_STATUS    8'h04
`define PRS_OFS_DENOM     8'h08
`define PRS_OFS_SPACING   8'h0c
`define PRS_OFS_RCOUNT    8'h10
`define PRS_OFS_SYNCCNT   8'h14
`define PRS_OFS_FREQ      8'h18
`define PRS_OFS_PHASE     8'h1c
`endif

/* shared/prs_pkg.sv */
// types shared by the phase realign and serial load slice
package prs_pkg;
  // latch chosen by the two control bits of a serial word
  typedef enum logic [1:0] {
    PRS_LATCH_FREQ  = 2'h0,
    PRS_LATCH_DENOM = 2'h1,
    PRS_LATCH_CTRL  = 2'h2,
    PRS_LATCH_AUX   = 2'h3
  } prs_latch_t;
  // realign arming state, one-hot
  typedef enum logic [2:0] {
    PRS_IDLE  = 3'b001,
    PRS_WAIT1 = 3'b010,
    PRS_WAIT2 = 3'b100
  } prs_arm_t;
  // synchronised serial pins
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic latch;
  } prs_ser_t;
  // captured ahb address phase
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] ofs;
  } prs_ahb_t;
endpackage : prs_pkg

/* rtl/prs_top.sv */
// serial load path, interpolator, realign timer and ahb-lite register slave
`timescale 1ns/100ps
`include "prs_regs.svh"
module prs_top
  import prs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        sclk,
  input  wire logic        sdata,
  input  wire logic        latch_enable_pin,
  input  wire logic        ref_in,
  input  wire logic        lock_detect,
  output logic             monitor_output_pin,
  output logic             sync_pulse,
  output logic             realign_pulse,
  output logic [11:0]      interp_code,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);
  // clamp a denominator to its legal floor
  function automatic logic [11:0] clamp_denom(input logic [11:0] v, input logic dith);
    logic [11:0] lo;
    lo = dith ? `PRS_DENOM_MIN_DITH : `PRS_DENOM_MIN;
    clamp_denom = (v < lo) ? lo : v;
  endfunction : clamp_denom

  prs_ser_t    s1;             // first sync stage, read only by s2
  prs_ser_t    s2;             // second sync stage
  prs_ser_t    s3;             // previous synced value for edges
  logic        ref1;           // reference first stage
  logic        ref2;           // reference second stage
  logic        ref3;           // reference previous value
  logic        lock1;          // lock first stage
  logic        lock2;          // lock synced
  logic        sclk_rise;      // serial clock rising edge
  logic        latch_rise;     // latch enable rising edge
  logic        ref_tick;       // one reference period elapsed
  logic [23:0] shreg;          // input shift register
  logic [8:0]  int_val;        // integer divider value
  logic [11:0] frac_val;       // fractional numerator
  logic [11:0] denom;          // fractional_denominator
  logic [10:0] spacing;        // realign spacing
  logic [3:0]  rcount;         // realign count
  logic        dither;         // dither enable
  logic        freq_load;      // new frequency committed
  logic        cfg_load;       // count or spacing rewritten
  logic [11:0] acc;            // interpolator accumulator
  logic [14:0] tmr;            // realign timer
  logic [14:0] period;         // count times spacing
  prs_arm_t    arm;            // realign arming state
  logic        done;           // sticky realign seen
  logic [15:0] sync_cnt;       // sync pulses issued
  logic [1:0]  mon_sel;        // monitor source select
  prs_ahb_t    ap;             // latched address phase
  logic [31:0] next_rdata;     // read mux

  // two-flop synchronisers for every pin input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // latch stages start at the pin's idle high, so no false commit follows reset
      s1    <= '{sclk: 1'b0, sdata: 1'b0, latch: 1'b1};
      s2    <= '{sclk: 1'b0, sdata: 1'b0, latch: 1'b1};
      s3    <= '{sclk: 1'b0, sdata: 1'b0, latch: 1'b1};
      ref1  <= 1'b0;
      ref2  <= 1'b0;
      ref3  <= 1'b0;
      lock1 <= 1'b0;
      lock2 <= 1'b0;
    end else if (ce) begin
      s1    <= '{sclk: sclk, sdata: sdata, latch: latch_enable_pin};
      s2    <= s1;
      s3    <= s2;
      ref1  <= ref_in;
      ref2  <= ref1;
      ref3  <= ref2;
      lock1 <= lock_detect;
      lock2 <= lock1;
    end
  end

  // edge finders on synced levels
  assign sclk_rise  = ce & s2.sclk & ~s3.sclk;
  assign latch_rise = ce & s2.latch & ~s3.latch;
  assign ref_tick   = ce & ref2 & ~ref3;   // [RL15]

  // shift data in on each serial clock rise, msb first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg <= '0;
    end else if (sclk_rise) begin
      shreg <= {shreg[22:0], s2.sdata};    // [RL1]
    end
  end

  // commit the word to the latch picked by its control bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_val   <= '0;
      frac_val  <= '0;
      denom     <= `PRS_DENOM_RST;
      spacing   <= `PRS_SPACING_RST;
      rcount    <= `PRS_RCOUNT_RST;        // [RL8]
      dither    <= 1'b0;
      freq_load <= 1'b0;
      cfg_load  <= 1'b0;
    end else if (ce) begin
      freq_load <= 1'b0;
      cfg_load  <= 1'b0;
      if (latch_rise) begin
        case (prs_latch_t'(shreg[`PRS_SEL_MSB:`PRS_SEL_LSB]))
          PRS_LATCH_FREQ: begin            // [RL1]
            int_val   <= shreg[`PRS_INT_MSB:`PRS_INT_LSB];
            frac_val  <= shreg[`PRS_FRAC_MSB:`PRS_FRAC_LSB];
            freq_load <= 1'b1;
          end
          PRS_LATCH_DENOM: begin
            if (shreg[`PRS_LOAD_SEL_BIT]) begin
              spacing  <= shreg[`PRS_DENOM_MSB:`PRS_DENOM_LSB];  // [RL9]
              cfg_load <= 1'b1;            // [RL17]
            end else begin
              denom <= clamp_denom({1'b0, shreg[`PRS_DENOM_MSB:`PRS_DENOM_LSB]},
                                   dither);  // [RL14]
            end
          end
          PRS_LATCH_CTRL: begin
            rcount   <= shreg[`PRS_RCOUNT_MSB:`PRS_RCOUNT_LSB];  // [RL7]
            dither   <= shreg[`PRS_DITHER_BIT];
            cfg_load <= 1'b1;              // [RL17]
          end
          default: begin
            // auxiliary latch holds nothing in this slice
          end
        endcase
      end
    end
  end

  // first-order interpolator, one step per reference period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc         <= '0;
      interp_code <= '0;
    end else if (ce) begin
      if (freq_load) begin
        acc         <= '0;                 // [RL16]
        interp_code <= '0;
      end else if (ref_tick) begin         // [RL15]
        if ({1'b0, acc} + {1'b0, frac_val} >= {1'b0, denom}) begin
          acc <= 12'(({1'b0, acc} + {1'b0, frac_val}) - {1'b0, denom});
        end else begin
          acc <= acc + frac_val;
        end
        interp_code <= acc;
      end
    end
  end

  // realign timer, counts reference periods up to count times spacing
  // both operands widened first so the product keeps all 15 bits
  assign period = {11'h000, rcount} * {4'h0, spacing};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr        <= '0;
      sync_pulse <= 1'b0;
    end else if (ce) begin
      sync_pulse <= 1'b0;
      if (cfg_load || rcount == 4'h0) begin
        tmr <= '0;                         // [RL17] [RL8]
      end else if (ref_tick) begin
        if (tmr >= period - 15'h0001) begin
          tmr        <= '0;
          sync_pulse <= 1'b1;              // [RL6]
        end else begin
          tmr <= tmr + 15'h0001;
        end
      end
    end
  end

  // arming: the second sync after a frequency load realigns
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arm           <= PRS_IDLE;
      realign_pulse <= 1'b0;
    end else if (ce) begin
      realign_pulse <= 1'b0;
      if (freq_load) begin
        arm <= PRS_WAIT1;                  // [RL11]
      end else begin
        case (arm)
          PRS_WAIT1: begin
            if (sync_pulse) begin
              arm <= PRS_WAIT2;
            end
          end
          PRS_WAIT2: begin
            if (sync_pulse) begin
              arm           <= PRS_IDLE;
              realign_pulse <= 1'b1;       // [RL11]
            end
          end
          default: begin
            arm <= PRS_IDLE;
          end
        endcase
      end
    end
  end

  // sticky realign flag and sync counter; set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done     <= 1'b0;
      sync_cnt <= '0;
    end else if (ce) begin
      if (realign_pulse) begin
        done <= 1'b1;
      end else if (ap.wr && ap.ofs == `PRS_OFS_STATUS && hwdata[0]) begin
        done <= 1'b0;
      end
      if (sync_pulse) begin
        sync_cnt <= sync_cnt + 16'h0001;
      end
    end
  end

  // monitor pin source select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      monitor_output_pin <= 1'b0;
    end else if (ce) begin
      case (mon_sel)
        2'h0:    monitor_output_pin <= lock2;  // [RL13]
        2'h1:    monitor_output_pin <= sync_pulse;
        2'h2:    monitor_output_pin <= done;
        default: monitor_output_pin <= 1'b0;
      endcase
    end
  end

  // ahb address phase capture, zero wait states
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ap <= '0;
    end else if (ce && hready) begin
      ap.wr  <= hsel & htrans[1] & hwrite;
      ap.rd  <= hsel & htrans[1] & ~hwrite;
      ap.ofs <= haddr[7:0];
    end else if (ce) begin
      ap.wr <= 1'b0;
      ap.rd <= 1'b0;
    end
  end

  // control register write in the data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_sel <= 2'h0;
    end else if (ce && ap.wr && ap.ofs == `PRS_OFS_CTRL) begin
      mon_sel <= hwdata[1:0];
    end
  end

  // read mux from the address phase; unmapped reads zero
  always_comb begin
    next_rdata = '0;
    if (haddr[7:0] == `PRS_OFS_CTRL) begin
      next_rdata = {30'h0, mon_sel};
    end else if (haddr[7:0] == `PRS_OFS_STATUS) begin
      next_rdata = {28'h0, dither, arm == PRS_IDLE, lock2, done};
    end else if (haddr[7:0] == `PRS_OFS_DENOM) begin
      next_rdata = {20'h0, denom};
    end else if (haddr[7:0] == `PRS_OFS_SPACING) begin
      next_rdata = {21'h0, spacing};
    end else if (haddr[7:0] == `PRS_OFS_RCOUNT) begin
      next_rdata = {28'h0, rcount};
    end else if (haddr[7:0] == `PRS_OFS_SYNCCNT) begin
      next_rdata = {16'h0, sync_cnt};
    end else if (haddr[7:0] == `PRS_OFS_FREQ) begin
      next_rdata = {11'h0, int_val, frac_val};
    end else if (haddr[7:0] == `PRS_OFS_PHASE) begin
      next_rdata = {17'h0, tmr};
    end
  end

  // read data registered at the address phase edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= '0;
    end else if (ce && hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  assign hreadyout = 1'b1;   // never stalls
  assign hresp     = 1'b0;   // always okay
endmodule : prs_top

/* sim/prs_top_monitor.sv */
// assertions on the outputs of the realign slice
`timescale 1ns/100ps
module prs_top_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        ref_in,
  input wire logic        latch_enable_pin,
  input wire logic        sync_pulse,
  input wire logic        realign_pulse,
  input wire logic [11:0] interp_code
);
  logic [3:0] since_evt; // clocks since a reference or latch rise
  logic       ref_d;     // reference pin one clock ago
  logic       le_d;      // latch pin one clock ago
  // age of the last event, frozen while ce is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {ref_d, le_d, since_evt} <= '0;
    end else if (ce) begin
      ref_d <= ref_in;
      le_d  <= latch_enable_pin;
      if ((ref_in && !ref_d) || (latch_enable_pin && !le_d)) begin
        since_evt <= '0;
      end else if (since_evt != 4'hf) begin
        since_evt <= since_evt + 4'h1;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_sync_gap; sync_pulse |=> !sync_pulse [*5]; endproperty
  a_sync_gap: assert property (p_sync_gap) else $error("sync pulses too close");
  property p_sync_tick; sync_pulse |-> since_evt < 4'h8; endproperty
  a_sync_tick: assert property (p_sync_tick) else $error("sync off tick");
  property p_interp_tick; $changed(interp_code) |-> since_evt < 4'h8; endproperty
  a_interp_tick: assert property (p_interp_tick) else $error("code moved off tick");
  property p_realign_one; realign_pulse |=> !realign_pulse; endproperty
  a_realign_one: assert property (p_realign_one) else $error("realign too long");
  property p_realign_sync; realign_pulse |-> sync_pulse || $past(sync_pulse); endproperty
  a_realign_sync: assert property (p_realign_sync) else $error("realign without sync");
  property p_ce_freeze; !ce |=> $stable(interp_code) && !$rose(sync_pulse); endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with ce low");
  property p_rst_quiet;
    disable iff (1'b0) !rst_n |-> !sync_pulse && !realign_pulse && interp_code == 12'h0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy in reset");
  property p_sync_one; sync_pulse |=> !sync_pulse; endproperty
  a_sync_one: assert property (p_sync_one) else $error("sync pulse too long");
endmodule : prs_top_monitor
bind prs_top prs_top_monitor i_mon (.clk, .rst_n, .ce, .ref_in, .latch_enable_pin,
  .sync_pulse, .realign_pulse, .interp_code);

/* sim/prs_host.sv */
// serial master model that writes 24-bit words to the slice
`timescale 1ns/100ps
module prs_host (
  output logic sclk,
  output logic sdata,
  output logic le
);
  // link idle: clock low and still, latch high
  initial begin
    sclk  = 1'b0;
    sdata = 1'b0;
    le    = 1'b1;
  end
  // one word, msb first, 400 ns clock period
  task send(input logic [23:0] w);
    le = 1'b0;
    #130;
    for (int i = 23; i >= 0; i--) begin
      sdata = w[i]; // data ahead of the rise
      #200 sclk = 1'b1;
      #200 sclk = 1'b0;
    end
    sdata = ~sdata; // released line shows no stale bit
    #130 le = 1'b1; // after the last bit only
  endtask : send
endmodule : prs_host

/* sim/tb_top.sv */
// self-checking bench for the realign slice
`timescale 1ns/100ps
`include "prs_regs.svh"
module tb_top;
  import prs_pkg::*;
  logic        clk, rst_n, ce, ref_in, ref_en, lock_detect, hsel, hwrite;
  logic [31:0] haddr, hwdata, rd, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize, div;
  wire logic   sclk, sdata, le, mon, syncp, realp, hrdy, hresp;
  wire logic [11:0] icode;
  wire logic [31:0] hrdata;
  int          fail_count, checked, ref_n, cyc, m_denom, n, seen;
  prs_host i_prs_host (.sclk(sclk), .sdata(sdata), .le(le));
  prs_top i_prs_top (.clk, .rst_n, .ce, .sclk, .sdata, .latch_enable_pin(le), .ref_in,
    .lock_detect, .monitor_output_pin(mon), .sync_pulse(syncp), .realign_pulse(realp),
    .interp_code(icode), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hrdy),
    .hreadyout(hrdy), .hresp(hresp), .hrdata);
  always #25 clk = ~clk;
  // reference every 8 clocks, tick counter and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ref_en) div <= div + 3'h1;
    if (ref_en && div == 3'h3) begin
      div    <= '0;
      ref_in <= ~ref_in;
      if (!ref_in) ref_n <= ref_n + 1;
    end
    if (cyc == 60000) begin
      fail_count++;
      print_verdict();
    end
  end
  task print_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // single ahb-lite word transfer, read data into rd
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a}; hsize <= 3'h2;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    htrans <= 2'h0; hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : ahb
  task ld(input logic [23:0] w);
    @(negedge clk);
    i_prs_host.send(w);
    repeat (8) @(posedge clk);
  endtask : ld
  task wsync();
    int k;
    k = 0;
    @(negedge clk);
    while (syncp !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 3000) begin
      fail_count++;
      $display("CHECK FAILED t=%0t no sync pulse", $time);
    end
  endtask : wsync
  // reference ticks between two sync pulses
  task period(input int exp);
    int p;
    wsync();
    p = ref_n;
    wsync();
    chk(ref_n - p, exp);
  endtask : period
  initial begin
    v = $urandom(32'h33cb);
    {clk, rst_n, ref_in, lock_detect, hsel, hwrite, htrans, hsize, div} = '0;
    {haddr, hwdata, cyc, ref_n, fail_count, checked} = '0;
    {ce, ref_en} = 2'b11;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    ahb(0, `PRS_OFS_DENOM, 0); chk(rd, 2);
    ahb(0, `PRS_OFS_SPACING, 0); chk(rd, 1);
    ahb(0, `PRS_OFS_RCOUNT, 0); chk(rd, 0);
    ahb(1, 8'h40, 32'hffff); ahb(0, 8'h40, 0); chk(rd, 0);
    repeat (200) @(posedge clk);
    ahb(0, `PRS_OFS_SYNCCNT, 0); chk(rd, 0);
    ld(24'h000009); ahb(0, `PRS_OFS_DENOM, 0); chk(rd, 2);
    m_denom = $urandom_range(2047, 2);
    ld({10'h0, m_denom[10:0], 3'h1}); ahb(0, `PRS_OFS_DENOM, 0); chk(rd, m_denom);
    ld({1'b1, 9'h0, 11'h004, 3'h1}); ahb(0, `PRS_OFS_SPACING, 0); chk(rd, 4);
    ahb(0, `PRS_OFS_DENOM, 0); chk(rd, m_denom);
    ld(24'h000011); ahb(0, `PRS_OFS_DENOM, 0); chk(rd, 2); // spacing a multiple
    ld(24'h002002); ahb(0, `PRS_OFS_RCOUNT, 0); chk(rd, 2);
    period(8);
    ld(24'h00f002); ld({1'b1, 9'h0, 11'h002, 3'h1}); // long interval
    period(30);
    v = $urandom;
    i_prs_host.send({1'b0, v[8:0], v[20:9], 2'h0});
    n = 0;
    seen = 0;
    repeat (800) begin
      @(negedge clk);
      if (syncp === 1'b1) n++;
      if (realp === 1'b1) begin
        seen = 1;
        break;
      end
    end
    chk(n, 2);
    chk(seen, 1);
    ahb(0, `PRS_OFS_FREQ, 0); chk(rd, {11'h0, v[8:0], v[20:9]});
    ahb(0, `PRS_OFS_STATUS, 0); chk(rd[0], 1);
    ahb(1, `PRS_OFS_CTRL, 2); repeat (6) @(posedge clk); chk(mon, 1);
    ahb(1, `PRS_OFS_STATUS, 1); ahb(0, `PRS_OFS_STATUS, 0); chk(rd[0], 0);
    repeat (2) @(posedge clk); chk(mon, 0);
    ahb(1, `PRS_OFS_CTRL, 1); wsync(); @(negedge clk); chk(mon, 1);
    ref_en <= 1'b0;
    ld({1'b0, v[8:0], v[20:9], 2'h0}); chk(icode, 0);
    ref_en <= 1'b1;
    lock_detect <= 1'b1;
    ahb(1, `PRS_OFS_CTRL, 0); repeat (6) @(posedge clk); chk(mon, 1);
    ahb(1, `PRS_OFS_CTRL, 3); repeat (6) @(posedge clk); chk(mon, 0);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    ld(24'h000006); ld(24'h000051); ahb(0, `PRS_OFS_DENOM, 0); chk(rd, 50);
    print_verdict();
  end
endmodule : tb_top
